/* File: core/payload_power_pkg.sv */
// constants for the switched payload power and timeout controller
// assumes a 100 MHz system clock and a one-shot command strobe
package payload_power_pkg;
	localparam int unsigned CLK_FREQ_HZ       = 100_000_000;
	localparam int unsigned TICK_PERIOD_S     = 1;
	localparam int unsigned TICK_CYCLES       = CLK_FREQ_HZ * TICK_PERIOD_S;
	localparam int unsigned TIMEOUT_S         = 86400;
	localparam int          CMD_W             = 8;
	localparam int          MODE_W            = 2;
	localparam int          TIMER_W           = 17;
	localparam logic [MODE_W-1:0] MODE_RESET  = 2'h0;
	localparam logic [MODE_W-1:0] MODE_RELAY  = 2'h1;
	localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(TIMEOUT_S);
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 17'h0;
	typedef enum logic {PWR_OFF, PWR_ON} pwr_state_e;
endpackage : payload_power_pkg

/* File: core/payload_power_timeout_control.sv */
// switched payload power control with 24 hour timeout
// assumes cmd_valid_in is a one-cycle strobe from logic on clk_in
`timescale 1ns/1ps
`default_nettype none

module payload_power_timeout_control
	import payload_power_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
	parameter logic [CMD_W-1:0] ACTIVATE_CODE_P = 8'h4c
)
(
	input  wire logic              clk_in,
	input  wire logic              reset_n_in,
	input  wire logic              cmd_valid_in,
	input  wire logic [CMD_W-1:0]  cmd_code_in,
	output var  logic              payload_enable_out,
	output var  logic [MODE_W-1:0] relay_operating_mode_out,
	output var  logic              timer_running_out,
	output var  logic [TIMER_W-1:0] seconds_left_out
);

	// ********************************
	// one-second tick divider
	// ********************************
	logic [31:0] div_r;
	logic [31:0] div_nxt;
	logic        tick_r;
	logic        tick_nxt;

	always_comb
	begin
		div_nxt  = div_r + 32'h1;
		tick_nxt = 1'b0;
		if (div_r >= TICK_CYCLES_P - 1)
		begin
			div_nxt  = 32'h0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			div_r  <= 32'h0;
			tick_r <= 1'b0;
		end
		else
		begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ********************************
	// power state, mode and countdown
	// ********************************
	pwr_state_e          state_r;
	pwr_state_e          state_nxt;
	logic [TIMER_W-1:0]  timer_r;
	logic [TIMER_W-1:0]  timer_nxt;
	logic [MODE_W-1:0]   mode_r;
	logic [MODE_W-1:0]   mode_nxt;
	logic                is_activate;

	assign is_activate = cmd_valid_in && (cmd_code_in == ACTIVATE_CODE_P);

	always_comb
	begin
		state_nxt = state_r;
		timer_nxt = timer_r;
		mode_nxt  = mode_r;
		if (is_activate)
		begin
			state_nxt = PWR_ON;
			mode_nxt  = MODE_RELAY;
			timer_nxt = TIMER_LOAD;
		end
		else if (cmd_valid_in)
		begin
			state_nxt = PWR_OFF;
			timer_nxt = TIMER_ZERO;
		end
		else
		begin
			unique case (state_r)
				PWR_ON:
				begin
					if (tick_r)
					begin
						if (timer_r <= 17'h1)
						begin
							state_nxt = PWR_OFF;
							timer_nxt = TIMER_ZERO;
						end
						else
						begin
							timer_nxt = timer_r - 17'h1;
						end
					end
				end
				PWR_OFF:
				begin
					timer_nxt = TIMER_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			state_r <= PWR_OFF;
			timer_r <= TIMER_ZERO;
			mode_r  <= MODE_RESET;
		end
		else
		begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
			mode_r  <= mode_nxt;
		end
	end

	// ********************************
	// outputs
	// ********************************
	logic enable_r;
	logic running_r;

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			enable_r  <= 1'b0;
			running_r <= 1'b0;
		end
		else
		begin
			enable_r  <= (state_nxt == PWR_ON);
			running_r <= (state_nxt == PWR_ON);
		end
	end

	assign payload_enable_out       = enable_r;
	assign relay_operating_mode_out = mode_r;
	assign timer_running_out        = running_r;
	assign seconds_left_out         = timer_r;

	// ********************************
	// assertions
	// ********************************
	sequence seq_activate;
		is_activate;
	endsequence

	sequence seq_other_cmd;
		cmd_valid_in && !is_activate;
	endsequence

	AST_ACT_ENABLE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		seq_activate |=> payload_enable_out)
		else $error("enable not raised by activation");
	AST_ACT_MODE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		seq_activate |=> relay_operating_mode_out == MODE_RELAY)
		else $error("mode not set by activation");
	AST_ACT_LOAD: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		seq_activate |=> seconds_left_out == TIMER_LOAD)
		else $error("timer not loaded");
	AST_RELOAD: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(timer_running_out and seq_activate) |=> timer_running_out && seconds_left_out == TIMER_LOAD)
		else $error("timer not reloaded");
	AST_OTHER_OFF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		seq_other_cmd |=> !payload_enable_out && !timer_running_out)
		else $error("other command did not power off");
	AST_EXPIRE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		timer_running_out && tick_r && seconds_left_out == 17'h1 && !cmd_valid_in
		|=> !payload_enable_out && seconds_left_out == TIMER_ZERO)
		else $error("expiry did not power off");
	AST_HALTED: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!timer_running_out && !cmd_valid_in |=> $stable(seconds_left_out) && !timer_running_out)
		else $error("halted timer moved");
	AST_STEP: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		timer_running_out && !tick_r && !cmd_valid_in |=> $stable(seconds_left_out))
		else $error("timer moved without tick");
	AST_ENABLE_MATCH: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		payload_enable_out == timer_running_out)
		else $error("enable and run state disagree");
	AST_RESET_OFF: assert property (@(posedge clk_in)
		!reset_n_in |=> !payload_enable_out && !timer_running_out && seconds_left_out == TIMER_ZERO)
		else $error("not off after reset");

endmodule : payload_power_timeout_control

`default_nettype wire

/* File: test/switched_payload.sv */
// model of the payload that reads the enable line
// assumes the enable comes straight from the controller
`timescale 1ns/1ps
`default_nettype none
module switched_payload
(
	input  wire logic enable_in,
	output var  logic powered_out
);
	// floating or low both mean off
	assign powered_out = (enable_in === 1'b1);
endmodule : switched_payload
`default_nettype wire

/* File: test/tb_payload_power_timeout_control.sv */
// bench for the payload power and timeout controller
// assumes a tick every 4 clocks on the main instance and every clock on the expiry instance
`timescale 1ns/1ps
`default_nettype none
module tb_payload_power_timeout_control;
	import payload_power_pkg::*;
	localparam logic [CMD_W-1:0] ACT = 8'h4c;
	localparam int               LIMIT = 90000;
	logic               clk_in;
	logic               reset_n_in;
	logic               cmd_valid_in;
	logic [CMD_W-1:0]   code;
	logic               en;
	logic               pw;
	logic               run;
	logic [MODE_W-1:0]  mode;
	logic [TIMER_W-1:0] secs;
	logic               en2;
	logic               run2;
	logic [TIMER_W-1:0] secs2;
	int                 fail_count = 0;
	int                 samples_checked = 0;
	int                 cycles = 0;
	payload_power_timeout_control #(.TICK_CYCLES_P(4), .ACTIVATE_CODE_P(ACT)) payload_power_timeout_control_i (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in), .cmd_code_in(code),
		.payload_enable_out(en), .relay_operating_mode_out(mode), .timer_running_out(run),
		.seconds_left_out(secs));
	// one tick per clock so that the full countdown fits in the run
	payload_power_timeout_control #(.TICK_CYCLES_P(1), .ACTIVATE_CODE_P(ACT)) payload_power_timeout_control_fast_i (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in), .cmd_code_in(code),
		.payload_enable_out(en2), .relay_operating_mode_out(), .timer_running_out(run2),
		.seconds_left_out(secs2));
	switched_payload switched_payload_i (.enable_in(en), .powered_out(pw));
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic check(input logic [TIMER_W-1:0] seen, input logic [TIMER_W-1:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		if (fail_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	task automatic send(input logic [CMD_W-1:0] c);
		@(posedge clk_in);
		cmd_valid_in <= 1'b1;
		code         <= c;
		@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		#1;
	endtask : send
	task automatic off_state(input logic [MODE_W-1:0] m);
		check(en, 1'b0);
		check(pw, 1'b0);
		check(run, 1'b0);
		check(secs, TIMER_ZERO);
		check(mode, m);
	endtask : off_state
	task automatic test_activate();
		send(ACT);
		check(pw, 1'b1);
		check(run, 1'b1);
		check(mode, MODE_RELAY);
		check(secs, TIMER_LOAD);
		repeat (20) @(posedge clk_in);
		#1;
		check(TIMER_LOAD - secs, 17'h5);
		check(en, 1'b1);
		send(ACT);
		check(secs, TIMER_LOAD);
	endtask : test_activate
	task automatic test_off();
		logic [CMD_W-1:0] codes [3] = '{8'h00, 8'h4d, 8'hff};
		foreach (codes[i])
		begin
			send(ACT);
			send(codes[i]);
			off_state(MODE_RELAY);
			repeat (9) @(posedge clk_in);
			#1;
			check(secs, TIMER_ZERO);
		end
	endtask : test_off
	task automatic test_reset();
		send(ACT);
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		@(posedge clk_in);
		reset_n_in <= 1'b1;
		#1;
		off_state(MODE_RESET);
	endtask : test_reset
	task automatic test_expire();
		send(ACT);
		check(secs2, TIMER_LOAD);
		repeat (TIMEOUT_S - 1) @(posedge clk_in);
		#1;
		check(secs2, 17'h1);
		check(en2, 1'b1);
		@(posedge clk_in);
		#1;
		check(en2, 1'b0);
		check(run2, 1'b0);
		check(secs2, TIMER_ZERO);
	endtask : test_expire
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			fail_count++;
			results();
		end
	end
	initial
	begin
		cmd_valid_in = 1'b0;
		code         = 8'h00;
		reset_n_in   = 1'b0;
		repeat (4) @(posedge clk_in);
		reset_n_in <= 1'b1;
		#1;
		off_state(MODE_RESET);
		test_activate();
		test_off();
		test_reset();
		test_expire();
		results();
	end
endmodule : tb_payload_power_timeout_control
`default_nettype wire
